// [rtl/frame_acquire_transfer_ctrl.sv]
// frame acquisition and buffered transfer controller with apb registers
// assumes frame strobes and link done come from logic on pclk
//
// What this block does
// - capture begin starts selected capture policy
// - halt ends after frame, unless multi-trigger; ends trigger wait at once
// - kill drops current frame or trigger wait
// - kill while idle is ignored
// - coupling select: basic or decoupled transfer
// - continuous transfer runs until halt command
// - counted transfer ends at count or halt
// - programmable block count for counted transfer
// - queued frame count readable
// - transfer begin, halt and kill commands
// - every frame stored, then sent promptly in basic mode
// - drop event only when store full
// - 256MB store, resend reserve reduces slots
// - basic mode: capture paced by transfer
// - decoupled: full store overwrites, raises drop
// - decoupled: transfer independent of capture
// - reject counted start above queued count
// - locked settings refused while busy
// - single, multi or continuous capture policy
`timescale 1ns/10ps
module frame_acquire_transfer_ctrl
  import fatc_pkg::*;
#(
  parameter longint FRAME_BYTES = 64'd1048576,
  parameter longint RESEND_BYTES = 64'd0
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sensor frame timing
  input wire logic frame_sof,
  input wire logic frame_eof,
  output logic capture_ready,
  output logic capture_active,
  // transfer link
  output logic block_send_req,
  output logic block_send_abort,
  input wire logic block_send_done,
  // events
  output logic frame_dropped_event
);
  localparam int SLOTS = int'((BUF_BYTES - RESEND_BYTES) / FRAME_BYTES);

  typedef enum {CAP_IDLE, CAP_WAIT, CAP_FRAME} cap_state_t;
  typedef enum {XF_IDLE, XF_RUN} xfer_state_t;

  frame_queue_if #(.CNT_W(CNT_W)) qif ();

  frame_slot_tracker #(.SLOTS(SLOTS), .CW(CNT_W)) u_tracker (
    .pclk(pclk),
    .presetn(presetn),
    .q(qif.tracker)
  );

  cap_state_t cap_q;
  xfer_state_t xf_q;
  logic [1:0] policy_q;
  logic coupling_q;
  logic run_policy_q;
  logic stream_open_q;
  logic [CNT_W-1:0] cap_count_q;
  logic [CNT_W-1:0] fpt_q;
  logic [CNT_W-1:0] xfer_count_q;
  logic [CNT_W-1:0] frames_done_q;
  logic [CNT_W-1:0] blocks_sent_q;
  logic [31:0] drops_q;
  logic [31:0] lock_q [LOCK_REGS];
  logic halt_pend_q;
  logic xf_halt_pend_q;
  logic rejected_q;
  logic cap_begin_q, cap_halt_q, cap_kill_q;
  logic xf_begin_q, xf_halt_q, xf_kill_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic ready_q;
  logic send_req_q;
  logic send_abort_q;
  logic dropped_q;
  logic setup;
  logic wr_acc;
  logic is_lock;
  logic locked;
  logic [LOCK_IDX_W-1:0] lock_idx;
  logic push;
  logic pop;
  logic decoupled;
  logic last_frame;
  logic last_block;
  logic frame_stop;
  logic active_q;

  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready_q && pwrite;
  assign is_lock = paddr >= ADDR_LOCK_BASE &&
    paddr < ADDR_LOCK_BASE + 8'(LOCK_REGS * 4);
  assign lock_idx = paddr[LOCK_IDX_LSB +: LOCK_IDX_W];
  assign decoupled = coupling_q;
  assign locked = cap_q != CAP_IDLE || xf_q != XF_IDLE || stream_open_q;

  // ---------------- apb slave: zero wait, answer flopped at setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr_q <= 1'b0;
    end
    else if (setup)
    begin
      pslverr_q <= paddr[1:0] != 2'h0 ||
        (paddr > ADDR_DROPS && !is_lock) ||
        (pwrite && (paddr == ADDR_QUEUED || paddr == ADDR_STATUS ||
          paddr == ADDR_DROPS)) ||
        (pwrite && is_lock && locked);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= '0;
    end
    else if (setup && !pwrite)
    begin
      prdata_q <= '0;
      case (paddr)
        ADDR_CTRL:
        begin
          prdata_q[CTRL_POLICY_LSB +: 2] <= policy_q;
          prdata_q[CTRL_COUPLE_BIT] <= coupling_q;
          prdata_q[CTRL_RUN_BIT] <= run_policy_q;
          prdata_q[CTRL_OPEN_BIT] <= stream_open_q;
        end
        ADDR_CAP_COUNT: prdata_q[CNT_W-1:0] <= cap_count_q;
        ADDR_FPT: prdata_q[CNT_W-1:0] <= fpt_q;
        ADDR_XFER_COUNT: prdata_q[CNT_W-1:0] <= xfer_count_q;
        ADDR_QUEUED: prdata_q[CNT_W-1:0] <= qif.count;
        ADDR_STATUS:
        begin
          prdata_q[ST_CAP_WAIT] <= cap_q == CAP_WAIT;
          prdata_q[ST_CAP_FRAME] <= cap_q == CAP_FRAME;
          prdata_q[ST_XFER_RUN] <= xf_q == XF_RUN;
          prdata_q[ST_QUEUE_FULL] <= qif.full;
          prdata_q[ST_REJECTED] <= rejected_q;
          prdata_q[ST_LOCKED] <= locked;
        end
        ADDR_DROPS: prdata_q <= drops_q;
        default:
        begin
          if (is_lock)
          begin
            prdata_q <= lock_q[lock_idx];
          end
        end
      endcase
    end
  end

  // ---------------- writable settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      policy_q <= POLICY_SINGLE;
      coupling_q <= 1'b0;
      run_policy_q <= 1'b0;
      stream_open_q <= 1'b0;
      cap_count_q <= CAP_COUNT_RST;
      fpt_q <= FPT_RST;
      xfer_count_q <= XFER_COUNT_RST;
    end
    else if (wr_acc && !pslverr_q)
    begin
      case (paddr)
        ADDR_CTRL:
        begin
          policy_q <= pwdata[CTRL_POLICY_LSB +: 2];
          coupling_q <= pwdata[CTRL_COUPLE_BIT];
          run_policy_q <= pwdata[CTRL_RUN_BIT];
          stream_open_q <= pwdata[CTRL_OPEN_BIT];
        end
        ADDR_CAP_COUNT: cap_count_q <= pwdata[CNT_W-1:0];
        ADDR_FPT: fpt_q <= pwdata[CNT_W-1:0];
        ADDR_XFER_COUNT: xfer_count_q <= pwdata[CNT_W-1:0];
        default:
        begin
        end
      endcase
    end
  end

  // pixel format, geometry, shading, preset, packet size and timeouts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < LOCK_REGS; i++)
      begin
        lock_q[i] <= '0;
      end
    end
    else if (wr_acc && is_lock && !pslverr_q)
    begin
      lock_q[lock_idx] <= pwdata;
    end
  end

  // ---------------- command pulses, never stored beyond one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {cap_begin_q, cap_halt_q, cap_kill_q} <= 3'h0;
      {xf_begin_q, xf_halt_q, xf_kill_q} <= 3'h0;
    end
    else
    begin
      cap_begin_q <= wr_acc && paddr == ADDR_CMD && pwdata[CMD_CAP_BEGIN];
      cap_halt_q <= wr_acc && paddr == ADDR_CMD && pwdata[CMD_CAP_HALT];
      cap_kill_q <= wr_acc && paddr == ADDR_CMD && pwdata[CMD_CAP_KILL];
      xf_begin_q <= wr_acc && paddr == ADDR_CMD && pwdata[CMD_XFER_BEGIN];
      xf_halt_q <= wr_acc && paddr == ADDR_CMD && pwdata[CMD_XFER_HALT];
      xf_kill_q <= wr_acc && paddr == ADDR_CMD && pwdata[CMD_XFER_KILL];
    end
  end

  // ---------------- capture sequencing
  assign last_frame = policy_q == POLICY_SINGLE ||
    (policy_q == POLICY_MULTI && frames_done_q + 1'b1 >= cap_count_q);
  assign push = cap_q == CAP_FRAME && frame_eof && !cap_kill_q;
  // a halt landing on the end-of-frame cycle obeys the same trigger-count exception
  assign frame_stop = last_frame || halt_pend_q || (cap_halt_q && fpt_q <= FPT_RST);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_q <= CAP_IDLE;
      active_q <= 1'b0;
      halt_pend_q <= 1'b0;
      frames_done_q <= '0;
    end
    else
    begin
      case (cap_q)
        CAP_IDLE:
        begin
          halt_pend_q <= 1'b0;
          if (cap_begin_q)
          begin
            cap_q <= CAP_WAIT;
            active_q <= 1'b1;
            frames_done_q <= '0;
          end
        end
        CAP_WAIT:
        begin
          if (cap_kill_q || cap_halt_q)
          begin
            cap_q <= CAP_IDLE;
            active_q <= 1'b0;
          end
          else if (frame_sof && ready_q)
          begin
            cap_q <= CAP_FRAME;
          end
        end
        CAP_FRAME:
        begin
          if (cap_kill_q)
          begin
            cap_q <= CAP_IDLE;
            active_q <= 1'b0;
          end
          else if (frame_eof)
          begin
            frames_done_q <= frames_done_q + 1'b1;
            cap_q <= frame_stop ? CAP_IDLE : CAP_WAIT;
            active_q <= !frame_stop;
          end
          else if (cap_halt_q && fpt_q <= FPT_RST)
          begin
            halt_pend_q <= 1'b1;
          end
        end
        default:
        begin
          cap_q <= CAP_IDLE;
          active_q <= 1'b0;
        end
      endcase
    end
  end
  // a kill in CAP_IDLE falls through the case untouched

  // basic mode holds the sensor off while the store is full
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ready_q <= 1'b1;
    end
    else
    begin
      ready_q <= decoupled || !qif.full;
    end
  end

  // ---------------- transfer sequencing
  assign last_block = run_policy_q && blocks_sent_q + 1'b1 >= xfer_count_q;
  assign pop = send_req_q && block_send_done;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xf_q <= XF_IDLE;
      blocks_sent_q <= '0;
      xf_halt_pend_q <= 1'b0;
    end
    else
    begin
      case (xf_q)
        XF_IDLE:
        begin
          xf_halt_pend_q <= 1'b0;
          blocks_sent_q <= '0;
          if (decoupled && xf_begin_q &&
            !(run_policy_q && xfer_count_q > qif.count))
          begin
            xf_q <= XF_RUN;
          end
        end
        XF_RUN:
        begin
          if (xf_kill_q || !decoupled)
          begin
            xf_q <= XF_IDLE;
          end
          else if (pop)
          begin
            blocks_sent_q <= blocks_sent_q + 1'b1;
            if (last_block || xf_halt_pend_q || xf_halt_q)
            begin
              xf_q <= XF_IDLE;
            end
          end
          else if (xf_halt_q && !send_req_q)
          begin
            xf_q <= XF_IDLE;
          end
          else if (xf_halt_q)
          begin
            xf_halt_pend_q <= 1'b1;
          end
        end
        default: xf_q <= XF_IDLE;
      endcase
    end
  end

  // sticky until the next transfer begin seen in XF_IDLE; software reads it in status
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rejected_q <= 1'b0;
    end
    else if (xf_begin_q && xf_q == XF_IDLE)
    begin
      rejected_q <= decoupled && run_policy_q && xfer_count_q > qif.count;
    end
  end

  // basic mode streams whenever a frame waits, with no flow control
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      send_req_q <= 1'b0;
      send_abort_q <= 1'b0;
    end
    else
    begin
      send_abort_q <= send_req_q && xf_kill_q && decoupled;
      if (pop || (xf_kill_q && decoupled))
      begin
        send_req_q <= 1'b0;
      end
      else if (!send_req_q && qif.count != '0)
      begin
        send_req_q <= decoupled ? (xf_q == XF_RUN && !xf_halt_q && !xf_halt_pend_q)
          : 1'b1;
      end
    end
  end

  // ---------------- drop events
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dropped_q <= 1'b0;
      drops_q <= '0;
    end
    else
    begin
      dropped_q <= qif.dropped;
      if (qif.dropped)
      begin
        drops_q <= drops_q + 1'b1;
      end
    end
  end

  assign qif.push = push;
  assign qif.pop = pop;
  assign qif.overwrite_ok = decoupled;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign capture_ready = ready_q;
  assign capture_active = active_q;
  assign block_send_req = send_req_q;
  assign block_send_abort = send_abort_q;
  assign frame_dropped_event = dropped_q;
endmodule

// [rtl/fatc_pkg.sv]
// constants shared by the frame acquisition / transfer controller files
// assumes a 32-bit apb register bus with byte addresses and one clock
package fatc_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_CAP_COUNT = 8'h08;
  localparam logic [7:0] ADDR_FPT = 8'h0c;
  localparam logic [7:0] ADDR_XFER_COUNT = 8'h10;
  localparam logic [7:0] ADDR_QUEUED = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_DROPS = 8'h1c;
  localparam logic [7:0] ADDR_LOCK_BASE = 8'h20;
  localparam int LOCK_REGS = 4;
  localparam int LOCK_IDX_LSB = 2;
  localparam int LOCK_IDX_W = 2;
  // command register bit positions (write-only, self clearing)
  localparam int CMD_CAP_BEGIN = 0;
  localparam int CMD_CAP_HALT = 1;
  localparam int CMD_CAP_KILL = 2;
  localparam int CMD_XFER_BEGIN = 3;
  localparam int CMD_XFER_HALT = 4;
  localparam int CMD_XFER_KILL = 5;
  // control register fields
  localparam int CTRL_POLICY_LSB = 0;
  localparam int CTRL_COUPLE_BIT = 4;
  localparam int CTRL_RUN_BIT = 8;
  localparam int CTRL_OPEN_BIT = 12;
  // capture_frame_policy encodings
  localparam logic [1:0] POLICY_SINGLE = 2'h0;
  localparam logic [1:0] POLICY_MULTI = 2'h1;
  localparam logic [1:0] POLICY_CONT = 2'h2;
  // status register bits
  localparam int ST_CAP_WAIT = 0;
  localparam int ST_CAP_FRAME = 1;
  localparam int ST_XFER_RUN = 2;
  localparam int ST_QUEUE_FULL = 3;
  localparam int ST_REJECTED = 4;
  localparam int ST_LOCKED = 5;
  // reset values
  localparam logic [15:0] CAP_COUNT_RST = 16'h0001;
  localparam logic [15:0] FPT_RST = 16'h0001;
  localparam logic [15:0] XFER_COUNT_RST = 16'h0001;
  localparam int CNT_W = 16;
  // frame store size in bytes
  localparam longint BUF_BYTES = 64'd268435456;
endpackage

// [rtl/frame_queue_if.sv]
// bundle between the controller and its frame slot tracker
// assumes both ends sit on the same clock
`timescale 1ns/10ps
interface frame_queue_if #(parameter int CNT_W = 16);
  logic push;
  logic pop;
  logic overwrite_ok;
  logic [CNT_W-1:0] count;
  logic full;
  logic dropped;
  modport owner (output push, output pop, output overwrite_ok,
    input count, input full, input dropped);
  modport tracker (input push, input pop, input overwrite_ok,
    output count, output full, output dropped);
endinterface

// [rtl/frame_slot_tracker.sv]
// occupancy of the circular frame store, counted in whole frame slots
// assumes push and pop are single-cycle pulses from the controller
`timescale 1ns/10ps
module frame_slot_tracker
  import fatc_pkg::*;
#(
  parameter int SLOTS = 256,
  parameter int CW = 16
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // queue bundle
  frame_queue_if.tracker q
);
  localparam logic [CW-1:0] SLOTS_C = CW'(SLOTS);
  logic [CW-1:0] count_q;
  logic dropped_q;

  // a push into a full store with no pop overwrites the oldest frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_q <= '0;
    end
    else if (q.push && !q.pop && count_q != SLOTS_C)
    begin
      count_q <= count_q + 1'b1;
    end
    else if (q.pop && !q.push && count_q != '0)
    begin
      count_q <= count_q - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dropped_q <= 1'b0;
    end
    else
    begin
      dropped_q <= q.push && !q.pop && count_q == SLOTS_C;
    end
  end

  assign q.count = count_q;
  assign q.full = (count_q == SLOTS_C);
  assign q.dropped = dropped_q;
endmodule

// [dv/fatc_sva.sv]
// assertion checker for the frame acquisition and transfer controller
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/10ps
module fatc_sva
  import fatc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // sensor, link and events
  input wire logic frame_sof,
  input wire logic frame_eof,
  input wire logic capture_ready,
  input wire logic capture_active,
  input wire logic block_send_req,
  input wire logic block_send_abort,
  input wire logic block_send_done,
  input wire logic frame_dropped_event
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic cmd_wr;
  logic lock_wr;
  assign acc = psel && penable && pready;
  assign cmd_wr = acc && pwrite && paddr == ADDR_CMD;
  assign lock_wr = acc && pwrite && paddr >= ADDR_LOCK_BASE && paddr <= 8'h2c;
  property p_rdy;
    psel && !penable |=> pready && penable;
  endproperty
  a_rdy: assert property (p_rdy) else $error("no answer after setup");
  property p_begin;
    cmd_wr && pwdata == (32'h1 << CMD_CAP_BEGIN) && !capture_active |-> ##[1:3] capture_active;
  endproperty
  a_begin: assert property (p_begin) else $error("capture did not start");
  property p_kill_idle;
    cmd_wr && pwdata == (32'h1 << CMD_CAP_KILL) && !capture_active |=> !capture_active [*3];
  endproperty
  a_kill_idle: assert property (p_kill_idle) else $error("idle kill acted");
  property p_kill;
    cmd_wr && pwdata[CMD_CAP_KILL] && capture_active |-> ##[1:3] !capture_active;
  endproperty
  a_kill: assert property (p_kill) else $error("kill did not end capture");
  property p_drop;
    frame_dropped_event |-> $past(frame_eof) || $past(frame_eof, 2) || $past(frame_eof, 3);
  endproperty
  a_drop: assert property (p_drop) else $error("drop without frame end");
  property p_req_hold;
    block_send_req && !block_send_done |=> block_send_req || block_send_abort;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("offer withdrawn early");
  property p_pop;
    block_send_req && block_send_done |=> !block_send_req;
  endproperty
  a_pop: assert property (p_pop) else $error("offer kept after done");
  property p_abort;
    block_send_abort |-> !block_send_req && $past(block_send_req);
  endproperty
  a_abort: assert property (p_abort) else $error("abort without offer");
  property p_cmd_rd;
    acc && !pwrite && paddr == ADDR_CMD |-> prdata == 32'h0;
  endproperty
  a_cmd_rd: assert property (p_cmd_rd) else $error("command reads nonzero");
  property p_lock;
    lock_wr && paddr[1:0] == 2'h0 && capture_active |-> pslverr;
  endproperty
  a_lock: assert property (p_lock) else $error("locked write accepted");
  c_drop: cover property (frame_dropped_event);
  c_abort: cover property (block_send_abort);
  c_run: cover property ($rose(capture_active));
endmodule
bind frame_acquire_transfer_ctrl fatc_sva chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .frame_sof, .frame_eof, .capture_ready,
  .capture_active, .block_send_req, .block_send_abort, .block_send_done,
  .frame_dropped_event);

// [dv/link_partner.sv]
// link model: finishes an offered block after a short latency
// assumes the offer is held until done; hold stalls the link
`timescale 1ns/10ps
module link_partner #(
  parameter int LAT = 3
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link
  input wire logic send_req,
  input wire logic send_abort,
  input wire logic hold,
  output logic send_done
);
  logic [7:0] wait_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wait_q <= 8'h0;
      send_done <= 1'b0;
    end
    else if (!send_req || send_abort || send_done || hold)
    begin
      // a stalled link restarts its count, like a congested network
      wait_q <= 8'h0;
      send_done <= 1'b0;
    end
    else
    begin
      wait_q <= wait_q + 8'h1;
      send_done <= (wait_q == 8'(LAT));
    end
  end
endmodule

// [dv/frame_acquire_transfer_ctrl_tb.sv]
// self-checking bench for the frame acquisition and transfer controller
// assumes four frame slots and the link model on the far side
`timescale 1ns/10ps
module frame_acquire_transfer_ctrl_tb;
  import fatc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, frame_sof, frame_eof, hold;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic pready, pslverr, serr, cap_rdy, cap_act, req, abort_p, done, drop;
  int err_total = 0;
  int n_checks = 0;
  int drops = 0;
  int aborts = 0;
  localparam logic [31:0] CPL = 32'h1 << CTRL_COUPLE_BIT;
  logic [7:0] ra [7] = '{ADDR_CAP_COUNT, ADDR_FPT, ADDR_XFER_COUNT, ADDR_CMD, ADDR_QUEUED,
    ADDR_CTRL, ADDR_DROPS};
  logic [31:0] rv [7] = '{32'h1, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
  frame_acquire_transfer_ctrl #(.FRAME_BYTES(64'd67108864)) dut_u (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .frame_sof, .frame_eof,
    .capture_ready(cap_rdy), .capture_active(cap_act), .block_send_req(req),
    .block_send_abort(abort_p), .block_send_done(done), .frame_dropped_event(drop));
  link_partner link_u (.pclk, .presetn, .send_req(req), .send_abort(abort_p), .hold,
    .send_done(done));
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    drops <= drops + int'(drop);
    aborts <= aborts + int'(abort_p);
  end
  task automatic summarize();
    if (err_total == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && i < 20)
    begin
      @(posedge pclk);
      i++;
    end
    if (i == 20)
    begin
      err_total++;
      summarize();
    end
    rdata = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic cmd(input int b);
    apb(1'b1, ADDR_CMD, 32'h1 << b);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rdata, exp);
  endtask
  // polls so that no link or capture latency is assumed
  task automatic poll(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    for (int i = 0; i < 60 && rdata !== exp; i++)
      apb(1'b0, a, 32'h0);
    chk(nm, rdata, exp);
  endtask
  task automatic frame(input bit kill, input bit halt = 1'b0);
    repeat (3) @(posedge pclk);
    frame_sof <= 1'b1;
    @(posedge pclk);
    frame_sof <= 1'b0;
    if (kill)
      cmd(CMD_CAP_KILL);
    if (halt)
      cmd(CMD_CAP_HALT);
    repeat (4) @(posedge pclk);
    frame_eof <= 1'b1;
    @(posedge pclk);
    frame_eof <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask
  initial
  begin
    {presetn, psel, penable, pwrite, frame_sof, frame_eof} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    hold = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 7; k++)
      rd("reset value", ra[k], rv[k]);
    wr(8'h30, 32'h1);
    chk("unmapped err", 32'(serr), 32'h1);
    wr(ADDR_QUEUED, 32'h3);
    chk("read-only err", 32'(serr), 32'h1);
    // basic single capture with a stalled link: the frame waits in the store
    cmd(CMD_CAP_BEGIN);
    frame(1'b0);
    poll("basic queued", ADDR_QUEUED, 32'h1);
    chk("single over", 32'(cap_act), 32'h0);
    chk("offered", 32'(req), 32'h1);
    hold <= 1'b0;
    poll("basic sent", ADDR_QUEUED, 32'h0);
    wr(ADDR_CTRL, 32'(POLICY_MULTI));
    wr(ADDR_CAP_COUNT, 32'h2);
    cmd(CMD_CAP_BEGIN);
    frame(1'b0);
    chk("multi running", 32'(cap_act), 32'h1);
    frame(1'b0);
    chk("multi over", 32'(cap_act), 32'h0);
    poll("multi sent", ADDR_QUEUED, 32'h0);
    cmd(CMD_CAP_KILL);
    chk("idle kill", 32'(cap_act), 32'h0);
    wr(ADDR_CTRL, CPL | 32'(POLICY_CONT));
    cmd(CMD_CAP_BEGIN);
    repeat (3) @(posedge pclk);
    wr(ADDR_LOCK_BASE, 32'h5a);
    chk("lock busy", 32'(serr), 32'h1);
    for (int k = 0; k < 5; k++)
    begin
      frame(1'b0);
      if (k == 3)
        chk("no early drop", 32'(drops), 32'h0);
    end
    chk("one drop", 32'(drops), 32'h1);
    rd("drop count", ADDR_DROPS, 32'h1);
    rd("store depth", ADDR_QUEUED, 32'h4);
    chk("ready decoupled", 32'(cap_rdy), 32'h1);
    cmd(CMD_CAP_HALT);
    repeat (3) @(posedge pclk);
    chk("halted", 32'(cap_act), 32'h0);
    wr(ADDR_LOCK_BASE, 32'h5a);
    rd("lock free", ADDR_LOCK_BASE, 32'h5a);
    cmd(CMD_CAP_BEGIN);
    frame(1'b1);
    chk("killed", 32'(cap_act), 32'h0);
    chk("no push", 32'(drops), 32'h1);
    wr(ADDR_FPT, 32'h2);
    cmd(CMD_CAP_BEGIN);
    frame(1'b0, 1'b1);
    chk("halt ignored", 32'(cap_act), 32'h1);
    wr(ADDR_FPT, 32'h1);
    frame(1'b0, 1'b1);
    chk("halt at frame end", 32'(cap_act), 32'h0);
    wr(ADDR_CTRL, CPL | (32'h1 << CTRL_RUN_BIT));
    wr(ADDR_XFER_COUNT, 32'h5);
    cmd(CMD_XFER_BEGIN);
    rd("reject", ADDR_STATUS, (32'h1 << ST_REJECTED) | (32'h1 << ST_QUEUE_FULL));
    wr(ADDR_XFER_COUNT, 32'h2);
    cmd(CMD_XFER_BEGIN);
    poll("counted", ADDR_QUEUED, 32'h2);
    repeat (10) @(posedge pclk);
    rd("counted end", ADDR_QUEUED, 32'h2);
    hold <= 1'b1;
    wr(ADDR_CTRL, CPL);
    cmd(CMD_XFER_BEGIN);
    repeat (4) @(posedge pclk);
    chk("offer", 32'(req), 32'h1);
    cmd(CMD_XFER_KILL);
    repeat (3) @(posedge pclk);
    chk("abort", 32'(aborts), 32'h1);
    rd("kept", ADDR_QUEUED, 32'h2);
    hold <= 1'b0;
    cmd(CMD_XFER_BEGIN);
    poll("drained", ADDR_QUEUED, 32'h0);
    rd("still on", ADDR_STATUS, (32'h1 << ST_XFER_RUN) | (32'h1 << ST_LOCKED));
    cmd(CMD_XFER_HALT);
    rd("stopped", ADDR_STATUS, 32'h0);
    summarize();
  end
endmodule
